// *** inc/sswt_pkg.sv ***
// ----------------------------------------------------------------------------
// Register map, field layout and timing constants of the space timing block.
// ----------------------------------------------------------------------------
package sswt_pkg;

    // Byte offsets on the APB register bus.
    localparam logic [11:0] OFS_WAIT_CTRL   = 12'h000;
    localparam logic [11:0] OFS_SETUP_CTRL  = 12'h004;
    localparam logic [11:0] OFS_STATUS      = 12'h008;

    // Field positions in the wait control register.
    localparam int WAIT_CODE_LSB   = 7;
    localparam int WAIT_CODE_MSB   = 10;
    localparam int EXT_IGNORE_BIT  = 6;
    localparam int HOLD_CODE_LSB   = 0;
    localparam int HOLD_CODE_MSB   = 1;

    // Field positions in the setup control register.
    localparam int SETUP_CODE_LSB  = 11;
    localparam int SETUP_CODE_MSB  = 12;

    // Field positions in the status register.
    localparam int STAT_BUSY_BIT   = 0;
    localparam int STAT_EXTW_BIT   = 1;

    // Reset values of the software fields.
    localparam logic [3:0] RST_WAIT_CODE  = 4'h_a;
    localparam logic       RST_EXT_IGNORE = 1'b0;
    localparam logic [1:0] RST_HOLD_CODE  = 2'h_0;
    localparam logic [1:0] RST_SETUP_CODE = 2'h_0;

    // Largest decoded wait count, also used for the prohibited codes.
    localparam logic [4:0] MAX_WAIT_CYCLES = 5'h_18;

    // Access sequencer states, one-hot.
    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_SETUP  = 4'b0010,
        ST_STROBE = 4'b0100,
        ST_HOLD   = 4'b1000
    } sswt_state_t;

endpackage

// *** verilog/sswt_wait_decode.sv ***
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------------------
// Wait code to bus-cycle count decoder.
// ----------------------------------------------------------------------------
module sswt_wait_decode
    import sswt_pkg::*;
(
    input  wire logic [3:0] waitCode,
    output logic      [4:0] waitCycles
);

    // Codes up to six map one to one; higher codes follow a stretched table.
    always_comb begin
        unique case (waitCode)
            4'h_0, 4'h_1, 4'h_2, 4'h_3,
            4'h_4, 4'h_5, 4'h_6: waitCycles = {1'b0, waitCode};
            4'h_7:               waitCycles = 5'h_08;
            4'h_8:               waitCycles = 5'h_0a;
            4'h_9:               waitCycles = 5'h_0c;
            4'h_a:               waitCycles = 5'h_0e;
            4'h_b:               waitCycles = 5'h_12;
            4'h_c:               waitCycles = MAX_WAIT_CYCLES;
            // Prohibited codes fall back to the longest wait, the safe side.
            default:             waitCycles = MAX_WAIT_CYCLES;
        endcase
    end

endmodule

`default_nettype wire

// *** verilog/sswt_space_ctrl.sv ***
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

// How it works
// - Wait code 0-6 gives 0-6 waits; 7..12 give 8,10,12,14,18,24 waits.
// - Ignore bit clear honours external wait; set ignores it.
// - External wait still stretches an access with zero programmed waits.
// - Bits 5 to 2 read zero; software writes zero there.
// - Address and select stay 0.5/1.5/2.5/3.5 cycles after strobes negate.
// - Strobes assert 0.5/1.5/2.5/3.5 cycles after address and select assert.

// ----------------------------------------------------------------------------
// Chip-select space access timing: APB registers and access sequencer.
// One bus cycle of the external memory is two clk_sys cycles, so the
// half-cycle figures are whole clk_sys cycles.
// ----------------------------------------------------------------------------
module sswt_space_ctrl
    import sswt_pkg::*;
#(
    parameter int ADDR_W = 24,
    parameter int DATA_W = 16,
    parameter int BE_W   = 2
) (
    input  wire logic              clk_sys,
    input  wire logic              nrst,
    // APB slave.
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic      [31:0]       prdata,
    // Access request port.
    input  wire logic              reqValid,
    input  wire logic              reqWrite,
    input  wire logic [ADDR_W-1:0] reqAddr,
    input  wire logic [DATA_W-1:0] reqWdata,
    input  wire logic [BE_W-1:0]   reqByteEn,
    output logic                   reqBusy,
    output logic                   rspValid,
    output logic      [DATA_W-1:0] rspRdata,
    // External memory pins.
    output logic      [ADDR_W-1:0] memAddr,
    output logic                   chipSelN,
    output logic                   readStrbN,
    output logic      [BE_W-1:0]   byteLaneSelN,
    output logic      [DATA_W-1:0] memDout,
    output logic                   memDoutEnN,
    input  wire logic [DATA_W-1:0] memDin,
    input  wire logic              extWaitN
);

    // ------------------------------------------------------------------------
    // State record.
    // ------------------------------------------------------------------------
    typedef struct packed {
        sswt_state_t       state;
        logic [5:0]        cnt;
        logic [3:0]        waitCode;
        logic              extIgnore;
        logic [1:0]        holdCode;
        logic [1:0]        setupCode;
        logic              isWrite;
        logic              extWaitSeen;
        logic              pready;
        logic              pslverr;
        logic [31:0]       prdata;
        logic              reqBusy;
        logic              rspValid;
        logic [DATA_W-1:0] rspRdata;
        logic [ADDR_W-1:0] memAddr;
        logic              chipSelN;
        logic              readStrbN;
        logic [BE_W-1:0]   byteLaneSelN;
        logic [DATA_W-1:0] memDout;
        logic              memDoutEnN;
    } sswt_reg_t;

    sswt_reg_t  st_ff;
    sswt_reg_t  nxt_st;
    logic [4:0] waitCycles;
    logic       apbSetup;
    logic       apbWrite;
    logic       extWaitActive;
    logic [5:0] strobeLoad;

    // ------------------------------------------------------------------------
    // Wait code decoding.
    // ------------------------------------------------------------------------
    sswt_wait_decode u_wait_decode (
        .waitCode   (st_ff.waitCode),
        .waitCycles (waitCycles)
    );

    // Bus phase qualifiers and the gated external wait.
    assign apbSetup      = psel & ~penable;
    assign apbWrite      = psel & penable & st_ff.pready & pwrite;
    assign extWaitActive = ~extWaitN & ~st_ff.extIgnore;
    // Strobe phase lasts one bus cycle plus the waits, two clocks each.
    assign strobeLoad    = {waitCycles, 1'b1};

    // ------------------------------------------------------------------------
    // Next-state logic.
    // ------------------------------------------------------------------------
    always_comb begin
        nxt_st          = st_ff;
        nxt_st.rspValid = 1'b0;

        // APB answers in the access phase right after each setup cycle.
        nxt_st.pready  = apbSetup;
        nxt_st.pslverr = 1'b0;
        if (apbSetup) begin
            nxt_st.prdata = 32'h_0000_0000;
            unique case (paddr)
                OFS_WAIT_CTRL: begin
                    // Reserved bits 5 to 2 stay zero in the read word.
                    nxt_st.prdata[WAIT_CODE_MSB:WAIT_CODE_LSB] = st_ff.waitCode;
                    nxt_st.prdata[EXT_IGNORE_BIT]              = st_ff.extIgnore;
                    nxt_st.prdata[HOLD_CODE_MSB:HOLD_CODE_LSB] = st_ff.holdCode;
                end
                OFS_SETUP_CTRL: begin
                    nxt_st.prdata[SETUP_CODE_MSB:SETUP_CODE_LSB] = st_ff.setupCode;
                end
                OFS_STATUS: begin
                    nxt_st.prdata[STAT_BUSY_BIT] = st_ff.reqBusy;
                    nxt_st.prdata[STAT_EXTW_BIT] = st_ff.extWaitSeen;
                end
                default: begin
                    nxt_st.pslverr = 1'b1;
                end
            endcase
        end

        // Register writes take effect at the completing edge only.
        if (apbWrite) begin
            unique case (paddr)
                OFS_WAIT_CTRL: begin
                    // Writes to bits 5 to 2 are dropped.
                    nxt_st.waitCode  = pwdata[WAIT_CODE_MSB:WAIT_CODE_LSB];
                    nxt_st.extIgnore = pwdata[EXT_IGNORE_BIT];
                    nxt_st.holdCode  = pwdata[HOLD_CODE_MSB:HOLD_CODE_LSB];
                end
                OFS_SETUP_CTRL: begin
                    nxt_st.setupCode = pwdata[SETUP_CODE_MSB:SETUP_CODE_LSB];
                end
                default: begin
                    nxt_st.setupCode = st_ff.setupCode;
                end
            endcase
        end

        // Access sequencer.
        unique case (st_ff.state)
            ST_IDLE: begin
                if (reqValid && !st_ff.reqBusy) begin
                    // Address and select assert; data drives on a write.
                    nxt_st.reqBusy     = 1'b1;
                    nxt_st.isWrite     = reqWrite;
                    nxt_st.memAddr     = reqAddr;
                    nxt_st.memDout     = reqWdata;
                    nxt_st.memDoutEnN  = ~reqWrite;
                    nxt_st.chipSelN    = 1'b0;
                    nxt_st.extWaitSeen = 1'b0;
                    nxt_st.cnt         = {3'h_0, st_ff.setupCode, 1'b0};
                    nxt_st.state       = ST_SETUP;
                    // Byte lanes stay negated here; the lane register keeps them for the write strobe phase.
                    nxt_st.byteLaneSelN = ~reqByteEn;
                    nxt_st.byteLaneSelN = {BE_W{1'b1}};
                end
            end
            ST_SETUP: begin
                if (st_ff.cnt == 6'h_00) begin
                    // Strobe asserts after 2*code+1 half bus cycles.
                    nxt_st.readStrbN = st_ff.isWrite;
                    nxt_st.cnt       = strobeLoad;
                    nxt_st.state     = ST_STROBE;
                end else begin
                    nxt_st.cnt = st_ff.cnt - 6'h_01;
                end
            end
            ST_STROBE: begin
                if (st_ff.cnt != 6'h_00) begin
                    nxt_st.cnt = st_ff.cnt - 6'h_01;
                end else if (extWaitActive) begin
                    // Hold the strobe until the external wait releases.
                    nxt_st.extWaitSeen = 1'b1;
                end else begin
                    nxt_st.rspRdata     = memDin;
                    nxt_st.readStrbN    = 1'b1;
                    nxt_st.byteLaneSelN = {BE_W{1'b1}};
                    nxt_st.cnt          = {3'h_0, st_ff.holdCode, 1'b0};
                    nxt_st.state        = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (st_ff.cnt == 6'h_00) begin
                    // Address and select negate 2*code+1 half cycles later.
                    nxt_st.chipSelN   = 1'b1;
                    nxt_st.memDoutEnN = 1'b1;
                    nxt_st.reqBusy    = 1'b0;
                    nxt_st.rspValid   = 1'b1;
                    nxt_st.state      = ST_IDLE;
                end else begin
                    nxt_st.cnt = st_ff.cnt - 6'h_01;
                end
            end
            default: begin
                nxt_st.state = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // Write strobe lanes follow the read strobe timing on a write access.
    // ------------------------------------------------------------------------
    logic [BE_W-1:0] laneEn_ff;
    logic [BE_W-1:0] nxt_laneEn;

    // Latch the requested lanes when an access is taken.
    always_comb begin
        nxt_laneEn = laneEn_ff;
        if (st_ff.state == ST_IDLE && reqValid && !st_ff.reqBusy) begin
            nxt_laneEn = reqByteEn;
        end
    end

    // Lane register.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            laneEn_ff <= '0;
        end else begin
            laneEn_ff <= nxt_laneEn;
        end
    end

    // ------------------------------------------------------------------------
    // State register.
    // ------------------------------------------------------------------------
    logic [BE_W-1:0] laneSelN_ff;
    logic [BE_W-1:0] nxt_laneSelN;

    // Write lanes assert with the strobe and negate with it.
    always_comb begin
        nxt_laneSelN = {BE_W{1'b1}};
        if (nxt_st.state == ST_STROBE && st_ff.isWrite) begin
            nxt_laneSelN = ~nxt_laneEn;
        end
    end

    // Registered copy of the whole state.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_ff            <= '0;
            st_ff.state      <= ST_IDLE;
            st_ff.waitCode   <= RST_WAIT_CODE;
            st_ff.extIgnore  <= RST_EXT_IGNORE;
            st_ff.holdCode   <= RST_HOLD_CODE;
            st_ff.setupCode  <= RST_SETUP_CODE;
            st_ff.chipSelN   <= 1'b1;
            st_ff.readStrbN  <= 1'b1;
            st_ff.memDoutEnN <= 1'b1;
            laneSelN_ff      <= {BE_W{1'b1}};
        end else begin
            st_ff       <= nxt_st;
            laneSelN_ff <= nxt_laneSelN;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs, all taken straight from flip-flops.
    // ------------------------------------------------------------------------
    assign pready       = st_ff.pready;
    assign pslverr      = st_ff.pslverr;
    assign prdata       = st_ff.prdata;
    assign reqBusy      = st_ff.reqBusy;
    assign rspValid     = st_ff.rspValid;
    assign rspRdata     = st_ff.rspRdata;
    assign memAddr      = st_ff.memAddr;
    assign chipSelN     = st_ff.chipSelN;
    assign readStrbN    = st_ff.readStrbN;
    assign byteLaneSelN = laneSelN_ff;
    assign memDout      = st_ff.memDout;
    assign memDoutEnN   = st_ff.memDoutEnN;

endmodule

`default_nettype wire

// *** dv/sswt_space_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none

// ------
// Pin and register bus checks.
// ------
module sswt_space_asserts
    import sswt_pkg::*;
#(
    parameter int BE_W = 2
) (
    input  wire logic            clk_sys,
    input  wire logic            nrst,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [11:0]     paddr,
    input  wire logic            pready,
    input  wire logic            pslverr,
    input  wire logic [31:0]     prdata,
    input  wire logic            reqValid,
    input  wire logic            reqBusy,
    input  wire logic            rspValid,
    input  wire logic            chipSelN,
    input  wire logic            readStrbN,
    input  wire logic [BE_W-1:0] byteLaneSelN,
    input  wire logic            memDoutEnN
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    // Any strobe, read or write.
    wire logic strb;
    assign strb = !readStrbN || !(&byteLaneSelN);

    // Shortest select window and one-cycle completion pulse.
    sequence selMin_s; !chipSelN [*4]; endsequence
    sequence strbMin_s; strb [*2]; endsequence
    sequence pulse_s; rspValid ##1 !rspValid; endsequence

    apb_answer_a: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("register bus answer not one cycle after setup");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error flag without ready");
    rsvd_zero_a: assert property (pready && !pwrite && paddr == OFS_WAIT_CTRL |-> prdata[5:2] == 4'h_0)
        else $error("reserved wait control bits read nonzero");
    take_select_a: assert property (reqValid && !reqBusy |=> !chipSelN && reqBusy)
        else $error("request not taken at once");
    setup_gap_a: assert property ($fell(chipSelN) |-> !strb)
        else $error("strobe together with select");
    hold_gap_a: assert property ($fell(strb) |-> !chipSelN)
        else $error("select dropped with strobe");
    sel_min_a: assert property ($fell(chipSelN) |-> selMin_s)
        else $error("select window too short");
    strb_min_a: assert property ($rose(strb) |-> strbMin_s)
        else $error("strobe too short");
    strb_sel_a: assert property (strb |-> !chipSelN)
        else $error("strobe outside select");
    done_pulse_a: assert property ($rose(chipSelN) |-> pulse_s)
        else $error("completion pulse missing");
    dout_sel_a: assert property (!memDoutEnN |-> !chipSelN)
        else $error("data driven outside select");
    lane_dout_a: assert property (!(&byteLaneSelN) |-> !memDoutEnN)
        else $error("write strobe without driven data");
endmodule

bind sswt_space_ctrl sswt_space_asserts #(.BE_W(BE_W)) u_asserts (
    .clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .reqValid(reqValid), .reqBusy(reqBusy), .rspValid(rspValid),
    .chipSelN(chipSelN), .readStrbN(readStrbN), .byteLaneSelN(byteLaneSelN),
    .memDoutEnN(memDoutEnN)
);

`default_nettype wire

// *** dv/sswt_mem_model.sv ***
`timescale 1ns/10ps
`default_nettype none

// ------
// External memory with a stall on its wait line.
// ------
module sswt_mem_model (
    input  wire logic        clk_sys,
    input  wire logic        chipSelN,
    input  wire logic        readStrbN,
    input  wire logic [1:0]  byteLaneSelN,
    input  wire logic [3:0]  addrLo,
    input  wire logic [15:0] memDout,
    input  wire logic [3:0]  stall,
    output logic      [15:0] memDin,
    output logic             extWaitN
);
    logic [15:0] mem [16];
    logic [15:0] lastDin = 16'h_0000;
    logic [3:0]  strbCnt = 4'h_0;
    wire  logic  strb;

    assign strb = !readStrbN || !(&byteLaneSelN);

    // Counts strobe cycles, stores enabled lanes, keeps the last word read.
    always @(posedge clk_sys) begin
        strbCnt <= strb ? strbCnt + 4'h_1 : 4'h_0;
        if (!readStrbN) begin
            lastDin <= mem[addrLo];
        end
        for (int i = 0; i < 2; i++) begin
            if (!chipSelN && !byteLaneSelN[i]) begin
                mem[addrLo][8*i +: 8] <= memDout[8*i +: 8];
            end
        end
    end

    // Released data shows the inverse of the last word, never a stale copy.
    assign memDin = (!chipSelN && !readStrbN) ? mem[addrLo] : ~lastDin;
    // Wait is held active for the first stall cycles of every strobe.
    assign extWaitN = !(strb && strbCnt < stall);

    // Memory starts cleared.
    initial begin
        foreach (mem[i]) begin
            mem[i] = 16'h_0000;
        end
    end
endmodule

`default_nettype wire

// *** dv/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none

// ------
// Self-checking bench of the space controller.
// ------
module tb_top
    import sswt_pkg::*;
;
    typedef struct packed {
        logic [3:0] code;
        logic [4:0] waits;
    } sswt_row_t;

    logic        clk_sys, nrst, psel, penable, pwrite, reqValid, reqWrite;
    logic        pready, pslverr, reqBusy, rspValid, chipSelN, readStrbN;
    logic        memDoutEnN, extWaitN;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [23:0] reqAddr, memAddr;
    logic [15:0] reqWdata, rspRdata, memDout, memDin;
    logic [1:0]  reqByteEn, byteLaneSelN;
    logic [3:0]  stall;
    wire  logic  strb;
    int          n_mismatch = 0;
    int          comparisons = 0;
    sswt_row_t   rows [13] = '{'{4'h_0, 5'h_00}, '{4'h_1, 5'h_01}, '{4'h_2, 5'h_02},
        '{4'h_3, 5'h_03}, '{4'h_4, 5'h_04}, '{4'h_5, 5'h_05}, '{4'h_6, 5'h_06},
        '{4'h_7, 5'h_08}, '{4'h_8, 5'h_0a}, '{4'h_9, 5'h_0c}, '{4'h_a, 5'h_0e},
        '{4'h_b, 5'h_12}, '{4'h_c, 5'h_18}};

    assign strb = !readStrbN || !(&byteLaneSelN);

    sswt_space_ctrl dut (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr),
        .reqWdata(reqWdata), .reqByteEn(reqByteEn), .reqBusy(reqBusy), .rspValid(rspValid),
        .rspRdata(rspRdata), .memAddr(memAddr), .chipSelN(chipSelN), .readStrbN(readStrbN),
        .byteLaneSelN(byteLaneSelN), .memDout(memDout), .memDoutEnN(memDoutEnN),
        .memDin(memDin), .extWaitN(extWaitN));

    sswt_mem_model u_mem (.clk_sys(clk_sys), .chipSelN(chipSelN), .readStrbN(readStrbN),
        .byteLaneSelN(byteLaneSelN), .addrLo(memAddr[3:0]), .memDout(memDout),
        .stall(stall), .memDin(memDin), .extWaitN(extWaitN));

    // Clock of 10 ns.
    always #5 clk_sys = ~clk_sys;

    // Prints the counts and the verdict.
    task automatic test_done;
        $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // A wait that ran out counts as a mismatch.
    task automatic hang;
        n_mismatch++;
        test_done();
    endtask

    // Compares one value.
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Compares one cycle count.
    task automatic chk_cnt(input int got, input int exp);
        chk_val(32'(got), 32'(exp));
    endtask

    // One register bus transfer, held until ready is sampled.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) hang();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    // Register write.
    task automatic wreg(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, a, d, rd, err);
    endtask

    // Register read with data and error compared.
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic expErr);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, a, 32'h_0000_0000, rd, err);
        chk_val(rd, exp);
        chk_val({31'h_0, err}, {31'h_0, expErr});
    endtask

    // One memory access; counts setup, strobe and hold cycles of the select.
    task automatic access(input logic wr, output int s, output int w, output int h);
        int n = 0;
        s = 0;
        w = 0;
        h = 0;
        reqValid <= 1'b1;
        reqWrite <= wr;
        @(posedge clk_sys);
        reqValid <= 1'b0;
        while (rspValid !== 1'b1 && n < 200) begin
            @(posedge clk_sys);
            n++;
            if (chipSelN === 1'b0) begin
                if (strb) w++;
                else if (w == 0) s++;
                else h++;
            end
        end
        if (n >= 200) hang();
    endtask

    // Main sequence.
    initial begin
        int s, w, h;
        clk_sys = 1'b0;
        nrst = 1'b0;
        {psel, penable, pwrite, reqValid, reqWrite} = 5'h_00;
        paddr = 12'h_000;
        pwdata = 32'h_0000_0000;
        {reqAddr, reqWdata, reqByteEn, stall} = '0;
        repeat (6) @(posedge clk_sys);
        chk_val({28'h_0, memDoutEnN, chipSelN, byteLaneSelN}, 32'h_0000_000f);
        nrst <= 1'b1;
        @(posedge clk_sys);
        rchk(OFS_WAIT_CTRL, 32'h_0000_0500, 1'b0);
        rchk(OFS_SETUP_CTRL, 32'h_0000_0000, 1'b0);
        rchk(12'h_00c, 32'h_0000_0000, 1'b1);
        wreg(OFS_WAIT_CTRL, 32'h_0000_003c);
        rchk(OFS_WAIT_CTRL, 32'h_0000_0000, 1'b0);
        // Every permitted wait code; the prohibited ones are never written.
        for (int i = 0; i < 13; i++) begin
            wreg(OFS_WAIT_CTRL, 32'(rows[i].code) << WAIT_CODE_LSB);
            access(1'b0, s, w, h);
            chk_cnt(w, 2 * (int'(rows[i].waits) + 1));
        end
        // Single byte lane write, then read back.
        reqAddr <= 24'h_00_0005;
        reqWdata <= 16'h_1234;
        reqByteEn <= 2'h_1;
        access(1'b1, s, w, h);
        access(1'b0, s, w, h);
        chk_val(32'(rspRdata), 32'h_0000_0034);
        // Setup and hold codes, each against its opposite.
        for (int k = 0; k < 4; k++) begin
            wreg(OFS_SETUP_CTRL, 32'(k) << SETUP_CODE_LSB);
            wreg(OFS_WAIT_CTRL, 32'(3 - k));
            access(1'b1, s, w, h);
            chk_cnt(s, 2 * k + 1);
            chk_cnt(h, 7 - 2 * k);
        end
        // External wait on a zero-wait access, honoured and then ignored.
        wreg(OFS_SETUP_CTRL, 32'h_0000_0000);
        wreg(OFS_WAIT_CTRL, 32'h_0000_0000);
        stall <= 4'h_4;
        access(1'b0, s, w, h);
        chk_cnt(w, 5);
        rchk(OFS_STATUS, 32'h_0000_0002, 1'b0);
        wreg(OFS_WAIT_CTRL, 32'h_0000_0040);
        access(1'b0, s, w, h);
        chk_cnt(w, 2);
        test_done();
    end
endmodule

`default_nettype wire
